// ===== include/gpio_ports_pkg.sv
/*
  Shared constants for the port B/C/D block: register indices, field
  positions and reset values.
  Assumes byte address = 4 * register index on the AXI4-Lite bus.
*/
package gpio_ports_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] idx_port_b_data = 8'h06;
  localparam logic [7:0] idx_port_c_data = 8'h07;
  localparam logic [7:0] idx_port_d_data = 8'h08;
  localparam logic [7:0] idx_interrupt_control = 8'h0b;
  localparam logic [7:0] idx_option_config = 8'h81;
  localparam logic [7:0] idx_port_b_direction = 8'h86;
  localparam logic [7:0] idx_port_c_direction = 8'h87;
  localparam logic [7:0] idx_port_d_direction = 8'h88;
  localparam logic [7:0] idx_port_e_direction_ctl = 8'h89;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int pullup_enable_n_bit = 7;
  localparam int ext_int_edge_select_bit = 6;
  localparam int change_flag_bit = 0;
  localparam int ext_int_flag_bit = 1;
  localparam int change_int_enable_bit = 3;
  localparam int parallel_slave_select_bit = 4;
  localparam int ext_int_pin_bit = 0;
  localparam int capture_compare_one_bit = 2;
  localparam int capture_compare_two_bit = 1;
  localparam logic [7:0] change_detect_mask = 8'hf0;
  localparam logic [7:0] port_e_ctl_mask = 8'h17;
  localparam logic [7:0] interrupt_control_mask = 8'h0b;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] option_config_reset = 8'hff;
  localparam logic [7:0] direction_reset = 8'hff;
  localparam logic [7:0] port_e_ctl_reset = 8'h07;
  localparam logic [7:0] latch_reset = 8'h00;
  localparam logic [7:0] interrupt_control_reset = 8'h00;
  // ---------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage : gpio_ports_pkg

// ===== src/gpio_ports_b_c_d.sv
/*
  General purpose ports B, C and D with AXI4-Lite register access,
  port B pull-ups, change detection and edge interrupt input, port C
  peripheral override and the port D parallel slave mode select.
  Assumes the pad ring resolves pins from out/oe/pullup and that all
  pin inputs are asynchronous to aclk.
*/
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - port B bit driven when direction 0
// - shared active-low bit enables all pull-ups
// - output pins never get a pull-up
// - pull-ups off after reset
// - only upper input pins compared for change
// - mismatch against value latched at last port B access sets change flag
// - change flag can wake from sleep
// - port B access refreshes comparison latch
// - persistent mismatch keeps setting the flag
// - port B bit 0 edge interrupt, edge selectable
// - port C bit driven when direction 0
// - enabled peripheral overrides port C direction
// - port C bits 2,1 carry capture/compare channels
// - port C direction resets to all inputs
// - port D bits individually input or output
// - mode bit only drives parallel_slave_select; port D pins keep latch/direction
// - reads return pins, writes update latch
module gpio_ports_b_c_d
  import gpio_ports_pkg::*;
#(
  parameter int addr_width = 12
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [addr_width-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [addr_width-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port b pins
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  output logic [7:0] port_b_pullup,
  // port c pins
  input wire logic [7:0] port_c_in,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_oe,
  // port c peripheral override
  input wire logic [7:0] periph_override_en,
  input wire logic [7:0] periph_override_dir,
  input wire logic [7:0] periph_out,
  output logic capture_compare_one_in,
  output logic capture_compare_two_in,
  // port d pins
  input wire logic [7:0] port_d_in,
  output logic [7:0] port_d_out,
  output logic [7:0] port_d_oe,
  // core side status
  output logic change_flag,
  output logic ext_int_flag,
  output logic wake_request,
  output logic parallel_slave_select
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] port_b_latch;
  logic [7:0] port_c_latch;
  logic [7:0] port_d_latch;
  logic [7:0] option_config;
  logic [7:0] port_b_direction;
  logic [7:0] port_c_direction;
  logic [7:0] port_d_direction;
  logic [7:0] port_e_direction_ctl;
  logic change_int_enable;
  // pin synchronisers: stage one feeds stage two only
  logic [23:0] pin_meta;
  logic [23:0] pin_sync;
  logic [7:0] pins_b;
  logic [7:0] pins_c;
  logic [7:0] pins_d;
  // change detection
  logic [7:0] compare_latch;
  logic mismatch;
  logic pin_b0_prev;
  logic ext_edge;
  // bus state
  logic aw_held;
  logic w_held;
  logic [7:0] aw_index;
  logic [7:0] w_byte;
  logic w_lane0;
  logic do_write;
  logic [7:0] ar_index;
  logic rd_take;
  logic [7:0] next_rdata;
  logic next_rerr;
  logic wr_hit;
  logic port_b_access;
  logic [7:0] c_dir_eff;

  // ---------------------------------------------------------------
  // pin input synchronisers
  // ---------------------------------------------------------------
  // two flops per pin; nothing reads pin_meta except pin_sync; no
  // reset, so both stages hold live levels when reset is released
  always_ff @(posedge aclk) begin
    pin_meta <= {port_d_in, port_c_in, port_b_in};
    pin_sync <= pin_meta;
  end
  assign pins_b = pin_sync[7:0];
  assign pins_c = pin_sync[15:8];
  assign pins_d = pin_sync[23:16];

  // ---------------------------------------------------------------
  // axi4-lite write path
  // ---------------------------------------------------------------
  // address and data are taken in either order and held until the
  // write commits; no new beat is taken while a response is pending
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_index <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_index <= s_axi_awaddr[9:2];
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // decode of the held write index
  always_comb begin
    unique case (aw_index)
      idx_port_b_data, idx_port_c_data, idx_port_d_data,
      idx_interrupt_control, idx_option_config, idx_port_b_direction,
      idx_port_c_direction, idx_port_d_direction,
      idx_port_e_direction_ctl: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // response one cycle after the commit; unmapped writes get slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= resp_okay;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? resp_okay : resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register file writes (byte lane 0 only carries data)
  // ---------------------------------------------------------------
  // output latches only; the pins are never written directly
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_b_latch <= latch_reset;
      port_c_latch <= latch_reset;
      port_d_latch <= latch_reset;
    end else if (do_write && w_lane0) begin
      if (aw_index == idx_port_b_data) port_b_latch <= w_byte;
      if (aw_index == idx_port_c_data) port_c_latch <= w_byte;
      if (aw_index == idx_port_d_data) port_d_latch <= w_byte;
    end
  end

  // configuration and direction registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      option_config <= option_config_reset;
      port_b_direction <= direction_reset;
      port_c_direction <= direction_reset;
      port_d_direction <= direction_reset;
      port_e_direction_ctl <= port_e_ctl_reset;
      change_int_enable <= 1'b0;
    end else if (do_write && w_lane0) begin
      unique case (aw_index)
        idx_option_config: option_config <= w_byte;
        idx_port_b_direction: port_b_direction <= w_byte;
        idx_port_c_direction: port_c_direction <= w_byte;
        idx_port_d_direction: port_d_direction <= w_byte;
        idx_port_e_direction_ctl: port_e_direction_ctl <= w_byte & port_e_ctl_mask;
        idx_interrupt_control: change_int_enable <= w_byte[change_int_enable_bit];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read path
  // ---------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign ar_index = s_axi_araddr[9:2];

  // port data reads return pin levels; port c direction reads back
  // the overridden value, so read-modify-write there is unsafe
  always_comb begin
    next_rerr = 1'b0;
    unique case (ar_index)
      idx_port_b_data: next_rdata = pins_b;
      idx_port_c_data: next_rdata = pins_c;
      idx_port_d_data: next_rdata = pins_d;
      idx_interrupt_control: next_rdata = {4'h0, change_int_enable, 1'b0,
                                           ext_int_flag, change_flag};
      idx_option_config: next_rdata = option_config;
      idx_port_b_direction: next_rdata = port_b_direction;
      idx_port_c_direction: next_rdata = c_dir_eff;
      idx_port_d_direction: next_rdata = port_d_direction;
      idx_port_e_direction_ctl: next_rdata = port_e_direction_ctl;
      default: begin
        next_rdata = 8'h00;
        next_rerr = 1'b1;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= resp_okay;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, next_rdata};
      s_axi_rresp <= next_rerr ? resp_slverr : resp_okay;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // port b drivers and pull-ups
  // ---------------------------------------------------------------
  // pull-up only on an input pin and only while the shared bit is low
  assign port_b_out = port_b_latch;
  assign port_b_oe = ~port_b_direction;
  assign port_b_pullup = option_config[pullup_enable_n_bit] ? 8'h00
                         : port_b_direction;

  // ---------------------------------------------------------------
  // port b change detection
  // ---------------------------------------------------------------
  // a read or a write of the port b data register refreshes the
  // compare value; polling therefore ends the mismatch that blocks a clear
  assign port_b_access = (rd_take && ar_index == idx_port_b_data)
                         || (do_write && aw_index == idx_port_b_data);
  assign mismatch = |((pins_b ^ compare_latch) & port_b_direction
                      & change_detect_mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_latch <= latch_reset;
    end else if (port_b_access) begin
      compare_latch <= pins_b;
    end
  end

  // set wins over a software clear, so the flag holds while mismatched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      change_flag <= 1'b0;
    end else if (mismatch) begin
      change_flag <= 1'b1;
    end else if (do_write && w_lane0 && aw_index == idx_interrupt_control
                 && !w_byte[change_flag_bit]) begin
      change_flag <= 1'b0;
    end
  end

  // wake request needs no clock edge from the core beyond this one
  assign wake_request = change_flag && change_int_enable;

  // ---------------------------------------------------------------
  // external interrupt on port b bit 0
  // ---------------------------------------------------------------
  // edge select high means rising edge
  assign ext_edge = option_config[ext_int_edge_select_bit]
                    ? (pins_b[ext_int_pin_bit] && !pin_b0_prev)
                    : (!pins_b[ext_int_pin_bit] && pin_b0_prev);

  // previous level follows the pin through reset, so a pin idling
  // high gives no false edge at release; an edge wins over a clear
  always_ff @(posedge aclk) begin
    pin_b0_prev <= pins_b[ext_int_pin_bit];
    if (!aresetn) begin
      ext_int_flag <= 1'b0;
    end else if (ext_edge) begin
      ext_int_flag <= 1'b1;
    end else if (do_write && w_lane0 && aw_index == idx_interrupt_control
                 && !w_byte[ext_int_flag_bit]) begin
      ext_int_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // port c with peripheral override
  // ---------------------------------------------------------------
  // an enabled peripheral forces direction and supplies output data
  assign c_dir_eff = (periph_override_en & periph_override_dir)
                     | (~periph_override_en & port_c_direction);
  assign port_c_oe = ~c_dir_eff;
  assign port_c_out = (periph_override_en & periph_out)
                      | (~periph_override_en & port_c_latch);
  assign capture_compare_one_in = pins_c[capture_compare_one_bit];
  assign capture_compare_two_in = pins_c[capture_compare_two_bit];

  // ---------------------------------------------------------------
  // port d and parallel slave select
  // ---------------------------------------------------------------
  assign port_d_out = port_d_latch;
  assign port_d_oe = ~port_d_direction;
  assign parallel_slave_select = port_e_direction_ctl[parallel_slave_select_bit];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence edge_seen_s;
    option_config[ext_int_edge_select_bit] && $rose(pins_b[ext_int_pin_bit]);
  endsequence
  sequence flag_up_s;
    ext_int_flag;
  endsequence

  b_drive_a: assert property ((port_b_oe ^ port_b_direction) == 8'hff)
    else $error("port b enable does not follow direction");
  pullup_ctl_a: assert property (option_config[pullup_enable_n_bit]
                                 |-> port_b_pullup == 8'h00)
    else $error("pull-up on while control bit set");
  pullup_out_a: assert property ((port_b_pullup & port_b_oe) == 8'h00)
    else $error("pull-up on an output pin");
  reset_pull_a: assert property (disable iff (1'b0) !aresetn |=> port_b_pullup == 8'h00)
    else $error("pull-up on after reset");
  change_excl_a: assert property (mismatch |-> |(port_b_direction & change_detect_mask))
    else $error("mismatch with no upper input pin");
  flag_hold_a: assert property (mismatch |=> change_flag)
    else $error("mismatch did not set change flag");
  wake_path_a: assert property (change_flag && change_int_enable |-> wake_request)
    else $error("wake not raised");
  access_refresh_a: assert property (port_b_access |=> compare_latch == $past(pins_b))
    else $error("compare latch not refreshed");
  ext_edge_a: assert property (edge_seen_s |=> flag_up_s)
    else $error("rising edge did not set flag");
  c_override_a: assert property ((periph_override_en
                                  & (periph_override_dir ~^ port_c_oe)) == 8'h00)
    else $error("override did not force direction");
  c_reset_a: assert property (disable iff (1'b0) !aresetn |=> port_c_direction == 8'hff)
    else $error("port c direction not all inputs after reset");
  psp_mode_a: assert property (do_write && w_lane0 && aw_index == idx_port_e_direction_ctl
                               |=> parallel_slave_select
                               == $past(w_byte[parallel_slave_select_bit]))
    else $error("slave port mode mismatch");
endmodule : gpio_ports_b_c_d
`default_nettype wire

// ===== bench/pad_model.sv
/*
  Pad model for one 8-bit port: resolves each pin from the block's
  driver, its pull-up and an external source.
  Assumes one clock; undriven, unpulled pins wander every cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module pad_model (
  // clock
  input wire logic aclk,
  // block side
  input wire logic [7:0] drive,
  input wire logic [7:0] oe,
  input wire logic [7:0] pull,
  // external source
  input wire logic [7:0] ext,
  input wire logic [7:0] ext_en,
  // resolved pin
  output logic [7:0] pin
);
  logic [7:0] drift = 8'h55;
  // a floating pin toggles so a stale value never passes for a level
  always @(posedge aclk) begin
    drift <= ~drift;
  end
  // block driver wins, then the outside source, then the pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin[i] = oe[i] ? drive[i] : ext_en[i] ? ext[i] : pull[i] ? 1'b1 : drift[i];
    end
  end
endmodule : pad_model
`default_nettype wire

// ===== bench/gpio_ports_b_c_d_test.sv
/*
  Self-checking bench for the port B/C/D block over AXI4-Lite.
  Assumes pad_model stands for the pins and outside world.
*/
`timescale 1ns/1ns
`default_nettype none
module gpio_ports_b_c_d_test
  import gpio_ports_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic bready = 1'b1;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic rready = 1'b1;
  logic [7:0] ext_b = 8'h00;
  logic [7:0] en_b = 8'hff;
  logic [7:0] ext_c = 8'h00;
  logic [7:0] ext_d = 8'h00;
  logic [7:0] ov_en = 8'h00;
  logic [7:0] ov_dir = 8'h00;
  logic [7:0] ov_out = 8'h00;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] pin_b, b_out, b_oe, b_pull, pin_c, c_out, c_oe, pin_d, d_out, d_oe;
  logic cc_one, cc_two, change_flag, ext_int_flag, wake_request, pss;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;

  // ---------------------------------------------------------------
  // clock, device and pads
  // ---------------------------------------------------------------
  always #20 aclk = ~aclk;
  gpio_ports_b_c_d #(.addr_width(12)) i_gpio_ports_b_c_d (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_b_in(pin_b), .port_b_out(b_out), .port_b_oe(b_oe), .port_b_pullup(b_pull),
    .port_c_in(pin_c), .port_c_out(c_out), .port_c_oe(c_oe),
    .periph_override_en(ov_en), .periph_override_dir(ov_dir), .periph_out(ov_out),
    .capture_compare_one_in(cc_one), .capture_compare_two_in(cc_two),
    .port_d_in(pin_d), .port_d_out(d_out), .port_d_oe(d_oe),
    .change_flag(change_flag), .ext_int_flag(ext_int_flag),
    .wake_request(wake_request), .parallel_slave_select(pss));
  pad_model i_pad_b (.aclk(aclk), .drive(b_out), .oe(b_oe), .pull(b_pull),
    .ext(ext_b), .ext_en(en_b), .pin(pin_b));
  pad_model i_pad_c (.aclk(aclk), .drive(c_out), .oe(c_oe), .pull(8'h00),
    .ext(ext_c), .ext_en(8'hff), .pin(pin_c));
  pad_model i_pad_d (.aclk(aclk), .drive(d_out), .oe(d_oe), .pull(8'h00),
    .ext(ext_d), .ext_en(8'hff), .pin(pin_d));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic print_verdict;
    if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // hang guard: the whole run needs well under two thousand cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // aw and w offered together, each dropped at its own handshake
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk({6'h0, bresp}, {6'h0, r});
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk(rdata[7:0], d);
    chk({6'h0, rresp}, {6'h0, r});
  endtask : rd
  // pins pass two sync flops before use, then a flag edge
  task automatic settle;
    repeat (5) @(posedge aclk);
  endtask : settle

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk(b_pull, 8'h00);
    chk(c_oe, 8'h00);
    rd(idx_option_config, 8'hff, resp_okay);
    rd(idx_port_b_direction, 8'hff, resp_okay);
    rd(idx_port_c_direction, 8'hff, resp_okay);
    rd(idx_interrupt_control, 8'h00, resp_okay);
  endtask : t_reset
  task automatic t_port_b;
    wr(idx_port_b_data, 8'ha5, resp_okay);
    wr(idx_port_b_direction, 8'h0f, resp_okay);
    wr(idx_option_config, 8'h7f, resp_okay);
    en_b <= 8'hfc;
    settle();
    chk(b_oe, 8'hf0);
    chk(b_out, 8'ha5);
    chk(b_pull, 8'h0f);
    rd(idx_port_b_data, 8'ha3, resp_okay);
    wr(idx_option_config, 8'hff, resp_okay);
    chk(b_pull, 8'h00);
    en_b <= 8'hff;
    wr(idx_port_b_direction, 8'hff, resp_okay);
  endtask : t_port_b
  // software leaves port B unpolled while it waits for the flag
  task automatic t_change;
    settle();
    rd(idx_port_b_data, 8'h00, resp_okay);
    wr(idx_interrupt_control, 8'h08, resp_okay);
    ext_b <= 8'h20;
    settle();
    chk({7'h0, change_flag}, 8'h01);
    chk({7'h0, wake_request}, 8'h01);
    wr(idx_interrupt_control, 8'h08, resp_okay);
    chk({7'h0, change_flag}, 8'h01);
    rd(idx_port_b_data, 8'h20, resp_okay);
    wr(idx_interrupt_control, 8'h08, resp_okay);
    chk({7'h0, change_flag}, 8'h00);
    ext_b <= 8'h21;
    settle();
    chk({7'h0, change_flag}, 8'h00);
    wr(idx_port_b_data, 8'h10, resp_okay);
    wr(idx_port_b_direction, 8'hef, resp_okay);
    settle();
    chk({7'h0, change_flag}, 8'h00);
    wr(idx_port_b_direction, 8'hff, resp_okay);
  endtask : t_change
  task automatic t_ext_int;
    wr(idx_interrupt_control, 8'h00, resp_okay);
    ext_b <= 8'h20;
    settle();
    chk({7'h0, ext_int_flag}, 8'h00);
    ext_b <= 8'h21;
    settle();
    chk({7'h0, ext_int_flag}, 8'h01);
    wr(idx_option_config, 8'hbf, resp_okay);
    wr(idx_interrupt_control, 8'h00, resp_okay);
    ext_b <= 8'h20;
    settle();
    chk({7'h0, ext_int_flag}, 8'h01);
    wr(idx_interrupt_control, 8'h00, resp_okay);
    ext_b <= 8'h21;
    settle();
    chk({7'h0, ext_int_flag}, 8'h00);
  endtask : t_ext_int
  // direction written whole, never read back and patched
  task automatic t_port_c;
    wr(idx_port_c_direction, 8'h00, resp_okay);
    wr(idx_port_c_data, 8'h38, resp_okay);
    chk(c_oe, 8'hff);
    chk(c_out, 8'h38);
    ov_en <= 8'h06;
    ov_dir <= 8'h04;
    ov_out <= 8'h02;
    ext_c <= 8'h04;
    settle();
    chk(c_oe, 8'hfb);
    chk(c_out & c_oe, 8'h3a);
    chk({6'h0, cc_one, cc_two}, 8'h03);
    rd(idx_port_c_direction, 8'h04, resp_okay);
    ov_en <= 8'h00;
    settle();
    chk(c_oe, 8'hff);
    chk({6'h0, cc_one, cc_two}, 8'h00);
  endtask : t_port_c
  task automatic t_port_d;
    wr(idx_port_d_direction, 8'h5a, resp_okay);
    wr(idx_port_d_data, 8'h81, resp_okay);
    chk(d_oe, 8'ha5);
    chk(d_out, 8'h81);
    settle();
    rd(idx_port_d_data, 8'h81, resp_okay);
    wstrb <= 4'he;
    wr(idx_port_d_direction, 8'h00, resp_okay);
    wstrb <= 4'hf;
    rd(idx_port_d_direction, 8'h5a, resp_okay);
    wr(idx_port_e_direction_ctl, 8'h10, resp_okay);
    chk({7'h0, pss}, 8'h01);
    rd(idx_port_e_direction_ctl, 8'h10, resp_okay);
    wr(idx_port_e_direction_ctl, 8'h07, resp_okay);
    chk({7'h0, pss}, 8'h00);
    wr(8'h40, 8'hff, resp_slverr);
    rd(8'h40, 8'h00, resp_slverr);
  endtask : t_port_d

  // main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_port_b();
    t_change();
    t_ext_int();
    t_port_c();
    t_port_d();
    print_verdict();
  end
endmodule : gpio_ports_b_c_d_test
`default_nettype wire
